// ==== pbo_pkg.sv ====
// shared constants, register map and state layout for the bit order / polarity block
package pbo_pkg;

  // ************************************************************
  // datapath and register map
  // ************************************************************
  localparam int DATA_W = 20;
  localparam int SUB_W8 = 8;
  localparam int SUB_W10 = 10;
  localparam int ADDR_W = 8;
  localparam int THR_W = 4;
  localparam int IRQ_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;
  localparam int CTRL_ERR_CLR_BIT = 7;
  localparam int IRQ_SD = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_ERR = 2;
  localparam logic [THR_W-1:0] THRESH_RST = 4'h7;
  localparam logic [6:0] LFSR_SEED = 7'h7f;
  localparam logic [5:0] DONE_WORDS = 6'h20;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_HUNT = 2'b01,
    CHK_LOCK = 2'b10
  } pbo_chk_e;

  typedef struct packed {
    logic chkEn;
    logic genSquare;
    logic genEn;
    logic statusEn;
    logic sdEn;
    logic sub10;
    logic txBitRev;
  } pbo_ctrl_s;

  localparam pbo_ctrl_s CTRL_RST = 7'h00;

  typedef struct packed {
    pbo_ctrl_s ctrl;
    logic [THR_W-1:0] thresh;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic errClr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic rxFlip1;
    logic rxFlip2;
    logic sdSync1;
    logic sdSync2;
    logic sigDetect;
    logic [DATA_W-1:0] txOut;
    logic txIdle;
    logic [DATA_W-1:0] rxOut;
    logic [6:0] genLfsr;
    logic sqPhase;
    logic [6:0] chkHist;
    pbo_chk_e chk;
    logic [5:0] goodCnt;
    logic prbsDone;
    logic prbsErr;
    logic prbsDoneOut;
    logic prbsErrOut;
  } pbo_state_s;

endpackage

// ==== pbo_bit_order_polarity_ctrl.sv ====
// pcs parallel datapath conditioning: bit/byte order, polarity, idle, signal detect, prbs
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module pbo_bit_order_polarity_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // fabric tx side
  input wire logic [19:0] txData,
  input wire logic txPolInv,
  input wire logic txElecIdle,
  // fabric rx side
  output logic [19:0] rxData,
  input wire logic rxPolInv,
  input wire logic rxByteRev,
  input wire logic rx_bit_order_flip_alt,
  output logic sigDetect,
  output logic prbsDone,
  output logic prbsErr,
  // pma side
  output logic [19:0] pmaTxData,
  output logic pmaTxElecIdle,
  input wire logic [19:0] pmaRxData,
  input wire logic pmaSdRaw,
  output logic [3:0] pmaSdThreshold
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [19:0] pbo_bit_rev(input logic [19:0] d);
    logic [19:0] r;
    r = 20'h00000;
    for (int i = 0; i < pbo_pkg::DATA_W; i++)
    begin
      r[i] = d[pbo_pkg::DATA_W-1-i];
    end
    return r;
  endfunction

  // 8-bit mode uses the low 16 bits only; upper nibble reads zero
  function automatic logic [19:0] pbo_sub_swap(input logic [19:0] d, input logic sub10);
    logic [19:0] r;
    r = sub10 ? {d[9:0], d[19:10]} : {4'h0, d[7:0], d[15:8]};
    return r;
  endfunction

  // bit i of result is stream bit i; low 7 are the seed, next 20 the new word
  function automatic logic [26:0] pbo_prbs_run(input logic [6:0] seed);
    logic [26:0] s;
    s = {20'h00000, seed};
    for (int i = 7; i < 27; i++)
    begin
      s[i] = s[i-7] ^ s[i-6];
    end
    return s;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  pbo_pkg::pbo_state_s st;
  pbo_pkg::pbo_state_s next_st;
  logic apbWr;
  logic [19:0] txSrc;
  logic [19:0] txRev;
  logic [19:0] rxPol;
  logic [19:0] rxSwap;
  logic [26:0] genRun;
  logic [26:0] chkRun;
  logic chkBad;
  logic [2:0] irqEv;
  logic [31:0] rdVal;
  logic rdErr;

  always_comb
  begin
    next_st = st;
    apbWr = psel && penable && pwrite && st.pready;
    next_st.pready = 1'b1;
    next_st.errClr = 1'b0;
    // register writes; no fabric port reaches txBitRev
    if (apbWr)
    begin
      unique case (paddr)
        pbo_pkg::ADDR_CTRL:
        begin
          next_st.ctrl = pbo_pkg::pbo_ctrl_s'(pwdata[6:0]);
          next_st.errClr = pwdata[pbo_pkg::CTRL_ERR_CLR_BIT];
        end
        pbo_pkg::ADDR_THRESH: next_st.thresh = pwdata[3:0];
        pbo_pkg::ADDR_IRQ_MASK: next_st.irqMask = pwdata[2:0];
        default: ;
      endcase
    end
    // read data is latched in the setup cycle so it stands through access
    rdErr = 1'b0;
    unique case (paddr)
      pbo_pkg::ADDR_CTRL: rdVal = {25'h0000000, st.ctrl};
      pbo_pkg::ADDR_THRESH: rdVal = {28'h0000000, st.thresh};
      pbo_pkg::ADDR_STATUS: rdVal = {28'h0000000, st.rxFlip2, st.prbsErr, st.prbsDone, st.sigDetect};
      pbo_pkg::ADDR_IRQ_STAT: rdVal = {29'h00000000, st.irqStat};
      pbo_pkg::ADDR_IRQ_MASK: rdVal = {29'h00000000, st.irqMask};
      default:
      begin
        rdVal = 32'h00000000;
        rdErr = 1'b1;
      end
    endcase
    if (psel && !penable)
    begin
      next_st.prdata = pwrite ? 32'h00000000 : rdVal;
      next_st.pslverr = rdErr;
    end

    // ************************************************************
    // transmit path
    // ************************************************************
    genRun = pbo_prbs_run(st.genLfsr);
    if (st.ctrl.genEn)
    begin
      txSrc = st.ctrl.genSquare ? {20{st.sqPhase}} : genRun[26:7];
      next_st.sqPhase = ~st.sqPhase;
      next_st.genLfsr = genRun[26:20];
    end
    else
    begin
      txSrc = txData;
    end
    txRev = st.ctrl.txBitRev ? pbo_bit_rev(txSrc) : txSrc;
    next_st.txOut = txRev ^ {20{txPolInv}};
    next_st.txIdle = txElecIdle;
    if (txElecIdle)
    begin
      next_st.txOut = 20'h00000;
    end

    // ************************************************************
    // receive path
    // ************************************************************
    // rx flip input may change at any time; only the second stage is used
    next_st.rxFlip1 = rx_bit_order_flip_alt;
    next_st.rxFlip2 = st.rxFlip1;
    rxPol = pmaRxData ^ {20{rxPolInv}};
    rxSwap = rxByteRev ? pbo_sub_swap(rxPol, st.ctrl.sub10) : rxPol;
    next_st.rxOut = st.rxFlip2 ? pbo_bit_rev(rxSwap) : rxSwap;

    // ************************************************************
    // signal detect
    // ************************************************************
    next_st.sdSync1 = pmaSdRaw;
    next_st.sdSync2 = st.sdSync1;
    next_st.sigDetect = st.ctrl.sdEn && st.sdSync2;

    // ************************************************************
    // prbs verifier, self-synchronising on the received stream
    // ************************************************************
    chkRun = pbo_prbs_run(st.chkHist);
    chkBad = chkRun[26:7] != rxPol;
    next_st.chkHist = rxPol[19:13];
    if (!st.ctrl.chkEn)
    begin
      next_st.chk = pbo_pkg::CHK_IDLE;
      next_st.goodCnt = 6'h00;
      next_st.prbsDone = 1'b0;
    end
    else if (st.errClr)
    begin
      next_st.chk = pbo_pkg::CHK_HUNT;
      next_st.goodCnt = 6'h00;
      next_st.prbsDone = 1'b0;
      next_st.prbsErr = 1'b0;
    end
    else
    begin
      unique case (st.chk)
        pbo_pkg::CHK_IDLE:
        begin
          next_st.chk = pbo_pkg::CHK_HUNT;
        end
        pbo_pkg::CHK_HUNT:
        begin
          next_st.goodCnt = chkBad ? 6'h00 : 6'(st.goodCnt + 6'h01);
          if (!chkBad && st.goodCnt == 6'(pbo_pkg::DONE_WORDS - 6'h01))
          begin
            next_st.chk = pbo_pkg::CHK_LOCK;
            next_st.prbsDone = 1'b1;
          end
        end
        pbo_pkg::CHK_LOCK:
        begin
          // sticky until cleared; loss of lock is not re-hunted automatically
          if (chkBad)
          begin
            next_st.prbsErr = 1'b1;
          end
        end
        default:
        begin
          next_st.chk = pbo_pkg::CHK_IDLE;
        end
      endcase
    end
    next_st.prbsDoneOut = st.ctrl.statusEn && next_st.prbsDone;
    next_st.prbsErrOut = st.ctrl.statusEn && next_st.prbsErr;

    // ************************************************************
    // interrupts, set beats write-one-to-clear
    // ************************************************************
    irqEv = {next_st.prbsErr && !st.prbsErr, next_st.prbsDone && !st.prbsDone,
             next_st.sigDetect && !st.sigDetect};
    if (apbWr && paddr == pbo_pkg::ADDR_IRQ_STAT)
    begin
      next_st.irqStat = (st.irqStat & ~pwdata[2:0]) | irqEv;
    end
    else
    begin
      next_st.irqStat = st.irqStat | irqEv;
    end
    next_st.irq = |(next_st.irqStat & next_st.irqMask);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.thresh <= pbo_pkg::THRESH_RST;
      st.ctrl <= pbo_pkg::CTRL_RST;
      st.genLfsr <= pbo_pkg::LFSR_SEED;
      st.chk <= pbo_pkg::CHK_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign rxData = st.rxOut;
  assign sigDetect = st.sigDetect;
  assign prbsDone = st.prbsDoneOut;
  assign prbsErr = st.prbsErrOut;
  assign pmaTxData = st.txOut;
  assign pmaTxElecIdle = st.txIdle;
  assign pmaSdThreshold = st.thresh;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_tx_bitrev;
    @(posedge core_clk) disable iff (!reset_n)
    st.ctrl.txBitRev && !st.ctrl.genEn && !txPolInv && !txElecIdle |=> pmaTxData == pbo_bit_rev($past(txData));
  endproperty
  a_tx_bitrev: assert property (p_tx_bitrev) else $error("tx word not bit reversed");
  property p_tx_static;
    @(posedge core_clk) disable iff (!reset_n)
    $changed(st.ctrl.txBitRev) |-> $past(apbWr) && $past(paddr) == pbo_pkg::ADDR_CTRL;
  endproperty
  a_tx_static: assert property (p_tx_static) else $error("tx reversal changed without register write");
  property p_rx_flip;
    @(posedge core_clk) disable iff (!reset_n)
    st.rxFlip2 && !rxPolInv && !rxByteRev |=> rxData == pbo_bit_rev($past(pmaRxData));
  endproperty
  a_rx_flip: assert property (p_rx_flip) else $error("rx word not msb first");
  property p_rx_sync;
    @(posedge core_clk) disable iff (!reset_n)
    rx_bit_order_flip_alt ##1 rx_bit_order_flip_alt |=> st.rxFlip2;
  endproperty
  a_rx_sync: assert property (p_rx_sync) else $error("rx flip not through two stages");
  property p_rx_byterev;
    @(posedge core_clk) disable iff (!reset_n)
    rxByteRev && st.ctrl.sub10 && !st.rxFlip2 && !rxPolInv |=>
      rxData == {$past(pmaRxData[9:0]), $past(pmaRxData[19:10])};
  endproperty
  a_rx_byterev: assert property (p_rx_byterev) else $error("rx sub-words not swapped");
  property p_tx_polinv;
    @(posedge core_clk) disable iff (!reset_n)
    txPolInv && !st.ctrl.txBitRev && !st.ctrl.genEn && !txElecIdle |=> pmaTxData == ~$past(txData);
  endproperty
  a_tx_polinv: assert property (p_tx_polinv) else $error("tx word not inverted");
  property p_rx_polinv;
    @(posedge core_clk) disable iff (!reset_n)
    rxPolInv && !rxByteRev && !st.rxFlip2 |=> rxData == ~$past(pmaRxData);
  endproperty
  a_rx_polinv: assert property (p_rx_polinv) else $error("rx word not inverted");
  property p_idle;
    @(posedge core_clk) disable iff (!reset_n)
    txElecIdle |=> pmaTxElecIdle && pmaTxData == 20'h00000;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not forced");
  property p_sd;
    @(posedge core_clk) disable iff (!reset_n)
    st.ctrl.sdEn && pmaSdRaw ##1 st.ctrl.sdEn && pmaSdRaw ##1 st.ctrl.sdEn |=> sigDetect;
  endproperty
  a_sd: assert property (p_sd) else $error("signal detect missed");
  property p_status_off;
    @(posedge core_clk) disable iff (!reset_n)
    !st.ctrl.statusEn |=> !prbsDone && !prbsErr;
  endproperty
  a_status_off: assert property (p_status_off) else $error("prbs status shown while disabled");
  property p_err_clear;
    @(posedge core_clk) disable iff (!reset_n)
    st.errClr && st.ctrl.chkEn |=> !st.prbsDone && !st.prbsErr && st.goodCnt == 6'h00;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error clear did not restart check");

  c_lock: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(st.prbsDone));
  c_err: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(st.prbsErr));
  c_irq: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(irq));

endmodule

// ==== pbo_pma_model.sv ====
// pma model: serializer/deserializer loopback and signal-detect comparator
`timescale 1ns/10ps
module pbo_pma_model (
  // clock
  input wire logic core_clk,
  // bench control
  input wire logic loopEn,
  input wire logic [19:0] rxWord,
  input wire logic sdLevel,
  // pma pins
  input wire logic [19:0] pmaTxData,
  input wire logic pmaTxElecIdle,
  input wire logic [3:0] pmaSdThreshold,
  output logic [19:0] pmaRxData,
  output logic pmaSdRaw
);
  logic [19:0] lastRx;
  always_ff @(posedge core_clk)
  begin
    lastRx <= pmaRxData;
  end
  // an idle line carries no word: show a changing pattern, never the last one
  always_comb
  begin
    if (!loopEn)
      pmaRxData = rxWord;
    else if (pmaTxElecIdle)
      pmaRxData = ~lastRx;
    else
      pmaRxData = pmaTxData;
  end
  // threshold is analog; the bench level stands in for the comparison
  assign pmaSdRaw = sdLevel && (pmaSdThreshold != 4'h0);
endmodule

// ==== pbo_bit_order_polarity_ctrl_bench.sv ====
// self-checking bench for the bit order / polarity block
`timescale 1ns/10ps
module pbo_bit_order_polarity_ctrl_bench;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] txData, rxData, pmaTxData, pmaRxData, rxWord, a, b;
  logic txPolInv, txElecIdle, rxPolInv, rxByteRev, rx_bit_order_flip_alt;
  logic sigDetect, prbsDone, prbsErr, pmaTxElecIdle, pmaSdRaw, loopEn, sdLevel, se;
  logic [3:0] pmaSdThreshold;
  int errCount = 0;
  int checksDone = 0;

  pbo_bit_order_polarity_ctrl u_dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .txData, .txPolInv, .txElecIdle, .rxData, .rxPolInv, .rxByteRev,
    .rx_bit_order_flip_alt, .sigDetect, .prbsDone, .prbsErr, .pmaTxData, .pmaTxElecIdle, .pmaRxData,
    .pmaSdRaw, .pmaSdThreshold);
  pbo_pma_model u_pma (.core_clk, .loopEn, .rxWord, .sdLevel, .pmaTxData, .pmaTxElecIdle,
    .pmaSdThreshold, .pmaRxData, .pmaSdRaw);

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (exp !== got)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      errCount++;
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      chk("pready", 32'h1, 32'h0);
      report_and_stop();
    end
  endtask

  task automatic waitSig(input int sel);
    int n;
    n = 0;
    while (((sel == 0) ? prbsDone : prbsErr) !== 1'b1 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 300)
    begin
      chk("prbs wait", 32'h1, 32'h0);
      report_and_stop();
    end
  endtask

  function automatic logic [19:0] rev20(input logic [19:0] d);
    logic [19:0] r;
    for (int i = 0; i < 20; i++)
      r[i] = d[19-i];
    return r;
  endfunction

  function automatic logic [19:0] rxExp(input logic [19:0] d, input logic [2:0] m, input logic fl);
    logic [19:0] t;
    t = m[0] ? ~d : d;
    if (m[1])
      t = m[2] ? {t[9:0], t[19:10]} : {4'h0, t[7:0], t[15:8]};
    return fl ? rev20(t) : t;
  endfunction

  initial
  begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, txPolInv, txElecIdle} = '0;
    {txData, rxPolInv, rxByteRev, rx_bit_order_flip_alt, loopEn, rxWord, sdLevel} = '0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // ************************************************************
    // reset values and unmapped access
    // ************************************************************
    chk("sdThreshold", 32'h7, {28'h0, pmaSdThreshold});
    apb(1'b0, pbo_pkg::ADDR_THRESH, 32'h0);
    chk("thresh", 32'h7, rd);
    chk("threshErr", 32'h0, {31'h0, se});
    apb(1'b1, pbo_pkg::ADDR_THRESH, 32'h3);
    apb(1'b0, pbo_pkg::ADDR_THRESH, 32'h0);
    chk("threshWr", 32'h3, rd);
    chk("sdThresholdWr", 32'h3, {28'h0, pmaSdThreshold});
    apb(1'b0, pbo_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, pbo_pkg::ADDR_IRQ_MASK, 32'h0);
    chk("mask", 32'h0, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se});
    chk("unmappedData", 32'h0, rd);
    $display("test reset done");
    // ************************************************************
    // tx reversal, polarity and idle
    // ************************************************************
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, pbo_pkg::ADDR_CTRL, {31'h0, i[0]});
      txData <= 20'h1234b;
      txPolInv <= i[1];
      repeat (2) @(posedge core_clk);
      a = i[0] ? rev20(20'h1234b) : 20'h1234b;
      chk("pmaTxData", {12'h0, i[1] ? ~a : a}, {12'h0, pmaTxData});
    end
    txElecIdle <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("idle", 32'h1, {11'h0, pmaTxData, pmaTxElecIdle});
    txElecIdle <= 1'b0;
    txPolInv <= 1'b0;
    $display("test tx done");
    // ************************************************************
    // rx polarity, sub-word swap and flip
    // ************************************************************
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, pbo_pkg::ADDR_CTRL, {30'h0, i[2], 1'b0});
      rxWord <= 20'h9c3a5;
      rxPolInv <= i[0];
      rxByteRev <= i[1];
      repeat (2) @(posedge core_clk);
      chk("rxData", {12'h0, rxExp(20'h9c3a5, i[2:0], 1'b0)}, {12'h0, rxData});
    end
    rx_bit_order_flip_alt <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("rxFlip", {12'h0, rxExp(20'h9c3a5, 3'h7, 1'b1)}, {12'h0, rxData});
    apb(1'b0, pbo_pkg::ADDR_STATUS, 32'h0);
    chk("flipStatus", 32'h8, rd & 32'h8);
    {rx_bit_order_flip_alt, rxPolInv, rxByteRev} <= 3'h0;
    $display("test rx done");
    // ************************************************************
    // signal detect and interrupt
    // ************************************************************
    sdLevel <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("sdOff", 32'h0, {31'h0, sigDetect});
    apb(1'b1, pbo_pkg::ADDR_CTRL, 32'h4);
    repeat (4) @(posedge core_clk);
    chk("sdOn", 32'h2, {30'h0, sigDetect, irq});
    apb(1'b1, pbo_pkg::ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irqOn", 32'h1, {31'h0, irq});
    apb(1'b1, pbo_pkg::ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irqClr", 32'h0, {31'h0, irq});
    $display("test sd done");
    // ************************************************************
    // prbs loopback, error clear, errors, square wave
    // ************************************************************
    loopEn <= 1'b1;
    apb(1'b1, pbo_pkg::ADDR_CTRL, 32'h58);
    waitSig(0);
    apb(1'b1, pbo_pkg::ADDR_CTRL, 32'hd8);
    repeat (2) @(posedge core_clk);
    chk("errClr", 32'h0, {30'h0, prbsDone, prbsErr});
    waitSig(0);
    txPolInv <= 1'b1;
    waitSig(1);
    apb(1'b0, pbo_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("irqStat", 32'h6, rd);
    txPolInv <= 1'b0;
    apb(1'b1, pbo_pkg::ADDR_CTRL, 32'h30);
    repeat (3) @(posedge core_clk);
    a = pmaTxData;
    @(posedge core_clk);
    b = pmaTxData;
    chk("square", 32'hfffff, {12'h0, a ^ b});
    chk("squareAnd", 32'h0, {12'h0, a & b});
    $display("test prbs done");
    report_and_stop();
  end
endmodule
